// *** shared/timer16_cc_defines.vh ***
// register map, field positions and constants of the capture/compare block
`ifndef TIMER16_CC_DEFINES_VH
`define TIMER16_CC_DEFINES_VH
`define TCC_ADDR_W 8
`define TCC_CTRL_A 8'h00
`define TCC_CTRL_B 8'h04
`define TCC_COUNT 8'h08
`define TCC_CAPTURE 8'h0C
`define TCC_CMP_A_HIGH 8'h10
`define TCC_CMP_A_LOW 8'h14
`define TCC_CMP_B_HIGH 8'h18
`define TCC_CMP_B_LOW 8'h1C
`define TCC_IRQ_MASK 8'h20
`define TCC_FLAGS 8'h24
`define TCC_FORCE 8'h28
`define TCC_ANCMP_CTRL 8'h2C
`define TCC_PORT_OUT 8'h30
`define TCC_STATUS 8'h34
`define TCC_B_FILTER 7
`define TCC_B_EDGE 6
`define TCC_B_WGM_HI 4
`define TCC_B_CLKEN 0
`define TCC_A_ACT_A 6
`define TCC_A_ACT_B 4
`define TCC_A_WGM_LO 0
`define TCC_F_CAPT 0
`define TCC_F_CMPA 1
`define TCC_F_CMPB 2
`define TCC_AC_SEL 0
`define TCC_FILTER_LEN 4
`define TCC_COUNT_MAX 16'hFFFF
`endif

// *** rtl/timer16_capture_compare.v ***
// capture trigger path and two compare channels of a 16-bit timer
`timescale 1ns/100ps
`include "timer16_cc_defines.vh"
module timer16_capture_compare (
  input wire clock,
  input wire reset,
  input wire clock_enable,
  input wire timer_tick,
  input wire capture_input_pin,
  input wire comparator_output,
  input wire capt_irq_ack,
  input wire cmpa_irq_ack,
  input wire cmpb_irq_ack,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg capture_irq,
  output reg compare_a_irq,
  output reg compare_b_irq,
  output reg [1:0] compare_output_state
);
  reg [7:0] ctrl_a_q;
  reg [7:0] timer_ctrl_b;
  reg [15:0] counter_value;
  reg [15:0] capture_value_reg;
  reg [7:0] compare_high_byte;
  reg [15:0] cmp_q [0:1];
  reg [15:0] cmp_buf_q [0:1];
  reg [2:0] irq_mask_q;
  reg capture_flag;
  reg [1:0] compare_flag;
  reg comparator_capture_select;
  reg port_out_q;
  reg block_q;
  reg [2:0] pin_sync_q;
  reg [2:0] ac_sync_q;
  reg pin_lvl_q;
  reg ac_lvl_q;
  reg [2:0] filt_sh_q;
  reg filt_q;
  reg edge_prev_q;
  reg [1:0] match_q;
  reg up_q;

  wire [3:0] waveform_mode_sel = {timer_ctrl_b[`TCC_B_WGM_HI+1:`TCC_B_WGM_HI],
                                  ctrl_a_q[`TCC_A_WGM_LO+1:`TCC_A_WGM_LO]};
  wire capture_filter_enable = timer_ctrl_b[`TCC_B_FILTER];
  wire edge_rise = timer_ctrl_b[`TCC_B_EDGE];
  wire tick = timer_tick & timer_ctrl_b[`TCC_B_CLKEN];
  wire acc = psel & penable;
  // writes act once, at the edge that raises pready
  wire wr = acc & pwrite & ~pready;
  wire non_pwm = (waveform_mode_sel == 4'd0) || (waveform_mode_sel == 4'd4) ||
                 (waveform_mode_sel == 4'd12);
  wire dual_slope = (waveform_mode_sel >= 4'd1 && waveform_mode_sel <= 4'd3) ||
                    (waveform_mode_sel >= 4'd8 && waveform_mode_sel <= 4'd11);
  wire icr_top = (waveform_mode_sel == 4'd8) || (waveform_mode_sel == 4'd10) ||
                 (waveform_mode_sel == 4'd12) || (waveform_mode_sel == 4'd14);
  wire ocra_top = (waveform_mode_sel == 4'd4) || (waveform_mode_sel == 4'd9) ||
                  (waveform_mode_sel == 4'd11) || (waveform_mode_sel == 4'd15);

  // counter top value per mode
  reg [15:0] top;
  always @* begin
    case (waveform_mode_sel)
      4'd1, 4'd5: top = 16'h00FF;
      4'd2, 4'd6: top = 16'h01FF;
      4'd3, 4'd7: top = 16'h03FF;
      default: begin
        if (icr_top)
          top = capture_value_reg;
        else if (ocra_top)
          top = cmp_q[0];
        else
          top = `TCC_COUNT_MAX;
      end
    endcase
  end

  wire at_top = (counter_value == top) && !block_q;
  wire at_bottom = (counter_value == 16'h0000);
  wire load_buf = dual_slope ? (at_top && up_q) : at_bottom;

  // capture source and sampler
  wire pin_src = capture_input_pin | port_out_q;
  wire raw_src = comparator_capture_select ? ac_lvl_q : pin_lvl_q;
  // window of four samples, the newest one still in front of the register
  wire [3:0] filt_win = {filt_sh_q, raw_src};
  wire filt_all = (filt_win == {`TCC_FILTER_LEN{raw_src}});
  wire filt_next = filt_all ? raw_src : filt_q;
  wire trig_lvl = capture_filter_enable ? filt_q : raw_src;
  wire capt_evt = !icr_top && (edge_rise ? (trig_lvl & ~edge_prev_q)
                                         : (~trig_lvl & edge_prev_q));

  wire [3:0] fld = paddr[5:2];
  wire known = (paddr[1:0] == 2'b00) && (paddr <= `TCC_STATUS);

  integer i;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_a_q <= 8'h00;
      timer_ctrl_b <= 8'h00;
      counter_value <= 16'h0000;
      capture_value_reg <= 16'h0000;
      compare_high_byte <= 8'h00;
      cmp_q[0] <= 16'h0000;
      cmp_q[1] <= 16'h0000;
      cmp_buf_q[0] <= 16'h0000;
      cmp_buf_q[1] <= 16'h0000;
      irq_mask_q <= 3'b000;
      capture_flag <= 1'b0;
      compare_flag <= 2'b00;
      comparator_capture_select <= 1'b0;
      port_out_q <= 1'b0;
      block_q <= 1'b0;
      pin_sync_q <= 3'b000;
      ac_sync_q <= 3'b000;
      pin_lvl_q <= 1'b0;
      ac_lvl_q <= 1'b0;
      filt_sh_q <= 3'h0;
      filt_q <= 1'b0;
      edge_prev_q <= 1'b0;
      match_q <= 2'b00;
      up_q <= 1'b1;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      capture_irq <= 1'b0;
      compare_a_irq <= 1'b0;
      compare_b_irq <= 1'b0;
      compare_output_state <= 2'b00;
    end else if (clock_enable) begin
      // three-stage sampler, level moves when stages two and three agree
      pin_sync_q <= {pin_sync_q[1:0], pin_src};
      ac_sync_q <= {ac_sync_q[1:0], comparator_output};
      if (pin_sync_q[1] == pin_sync_q[2])
        pin_lvl_q <= pin_sync_q[2];
      if (ac_sync_q[1] == ac_sync_q[2])
        ac_lvl_q <= ac_sync_q[2];
      filt_sh_q <= {filt_sh_q[1:0], raw_src};
      filt_q <= filt_next;
      edge_prev_q <= trig_lvl;

      // counter
      if (wr && paddr == `TCC_COUNT) begin
        counter_value <= pwdata[15:0];
        block_q <= 1'b1;
      end else if (tick) begin
        block_q <= 1'b0;
        if (dual_slope) begin
          if (at_top && up_q) begin
            up_q <= 1'b0;
            counter_value <= counter_value - 16'h0001;
          end else if (at_bottom && !up_q) begin
            up_q <= 1'b1;
            counter_value <= counter_value + 16'h0001;
          end else if (up_q)
            counter_value <= counter_value + 16'h0001;
          else
            counter_value <= counter_value - 16'h0001;
        end else if (at_top && top != `TCC_COUNT_MAX)
          counter_value <= 16'h0000;
        else
          counter_value <= counter_value + 16'h0001;
      end

      // capture
      if (capt_evt)
        capture_value_reg <= counter_value;
      else if (wr && paddr == `TCC_CAPTURE && icr_top)
        capture_value_reg <= pwdata[15:0];

      // compare channels
      for (i = 0; i < 2; i = i + 1) begin
        if (tick)
          match_q[i] <= (counter_value == cmp_q[i]) && !block_q;
        else
          match_q[i] <= 1'b0;
        if (!non_pwm && tick && load_buf)
          cmp_q[i] <= cmp_buf_q[i];
        if (wr && paddr == `TCC_CMP_A_LOW + 8'h08 * i[7:0]) begin
          if (non_pwm)
            cmp_q[i] <= {compare_high_byte, pwdata[7:0]};
          else
            cmp_buf_q[i] <= {compare_high_byte, pwdata[7:0]};
        end
      end
      if (wr && (paddr == `TCC_CMP_A_HIGH || paddr == `TCC_CMP_B_HIGH))
        compare_high_byte <= pwdata[7:0];

      // output state update, actions read live
      compare_output_state[0] <= out_next(compare_output_state[0],
        ctrl_a_q[`TCC_A_ACT_A+1:`TCC_A_ACT_A],
        match_q[0] || (wr && paddr == `TCC_FORCE && pwdata[0] && non_pwm));
      compare_output_state[1] <= out_next(compare_output_state[1],
        ctrl_a_q[`TCC_A_ACT_B+1:`TCC_A_ACT_B],
        match_q[1] || (wr && paddr == `TCC_FORCE && pwdata[1] && non_pwm));

      // flags: hardware set beats clear
      capture_flag <= capt_evt | (capture_flag & ~capt_irq_ack &
        ~(wr && paddr == `TCC_FLAGS && pwdata[`TCC_F_CAPT]));
      compare_flag[0] <= match_q[0] | (compare_flag[0] & ~cmpa_irq_ack &
        ~(wr && paddr == `TCC_FLAGS && pwdata[`TCC_F_CMPA]));
      compare_flag[1] <= match_q[1] | (compare_flag[1] & ~cmpb_irq_ack &
        ~(wr && paddr == `TCC_FLAGS && pwdata[`TCC_F_CMPB]));
      capture_irq <= capture_flag & irq_mask_q[`TCC_F_CAPT];
      compare_a_irq <= compare_flag[0] & irq_mask_q[`TCC_F_CMPA];
      compare_b_irq <= compare_flag[1] & irq_mask_q[`TCC_F_CMPB];

      // register writes
      if (wr) begin
        case (paddr)
          `TCC_CTRL_A: ctrl_a_q <= pwdata[7:0];
          `TCC_CTRL_B: timer_ctrl_b <= pwdata[7:0];
          `TCC_IRQ_MASK: irq_mask_q <= pwdata[2:0];
          `TCC_ANCMP_CTRL: comparator_capture_select <= pwdata[`TCC_AC_SEL];
          `TCC_PORT_OUT: port_out_q <= pwdata[0];
          default: ;
        endcase
      end

      // apb slave: one wait state
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~known;
      prdata <= 32'h0000_0000;
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          `TCC_CTRL_A: prdata <= {24'h000000, ctrl_a_q};
          `TCC_CTRL_B: prdata <= {24'h000000, timer_ctrl_b};
          `TCC_COUNT: prdata <= {16'h0000, counter_value};
          `TCC_CAPTURE: prdata <= {16'h0000, capture_value_reg};
          `TCC_CMP_A_HIGH: prdata <= {24'h000000,
            non_pwm ? cmp_q[0][15:8] : cmp_buf_q[0][15:8]};
          `TCC_CMP_A_LOW: prdata <= {24'h000000,
            non_pwm ? cmp_q[0][7:0] : cmp_buf_q[0][7:0]};
          `TCC_CMP_B_HIGH: prdata <= {24'h000000,
            non_pwm ? cmp_q[1][15:8] : cmp_buf_q[1][15:8]};
          `TCC_CMP_B_LOW: prdata <= {24'h000000,
            non_pwm ? cmp_q[1][7:0] : cmp_buf_q[1][7:0]};
          `TCC_IRQ_MASK: prdata <= {29'h0, irq_mask_q};
          `TCC_FLAGS: prdata <= {29'h0, compare_flag, capture_flag};
          `TCC_ANCMP_CTRL: prdata <= {31'h0, comparator_capture_select};
          `TCC_PORT_OUT: prdata <= {31'h0, port_out_q};
          `TCC_STATUS: prdata <= {28'h0, up_q, filt_q, compare_output_state};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // next output state from action bits: 1 toggle, 2 clear, 3 set
  function out_next;
    input cur;
    input [1:0] act;
    input hit;
    begin
      if (!hit)
        out_next = cur;
      else
        case (act)
          2'd1: out_next = ~cur;
          2'd2: out_next = 1'b0;
          2'd3: out_next = 1'b1;
          default: out_next = cur;
        endcase
    end
  endfunction
endmodule

// *** testbench/event_source.sv ***
// external event source driving the two capture inputs
`timescale 1ns/100ps
module event_source (
  input wire clock,
  input wire go,
  input wire sel,
  input wire [3:0] width,
  output wire capture_input_pin,
  output wire comparator_output
);
  reg [3:0] left_q = 4'h0;
  // a pulse of width cycles on the selected input, both idle low
  always @(posedge clock) begin
    left_q <= go ? width : left_q - {3'h0, left_q != 4'h0};
  end
  assign capture_input_pin = !sel && left_q != 4'h0;
  assign comparator_output = sel && left_q != 4'h0;
endmodule

// *** testbench/timer16_cc_monitor.sv ***
// bus and compare interrupt assertions of the timer block
`timescale 1ns/100ps
module timer16_cc_monitor (
  input wire clock,
  input wire reset,
  input wire timer_tick,
  input wire cmpa_irq_ack,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire compare_a_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_bad;
    s_wait ##0 (paddr > 8'h34 || paddr[1:0] != 2'h0);
  endsequence
  sequence s_good;
    s_wait ##0 paddr <= 8'h34 ##0 paddr[1:0] == 2'h0;
  endsequence
  a_ready_wait: assert property (s_wait |=> pready)
    else $error("no ready after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_phase: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_err_unmapped: assert property (s_bad |=> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (s_good |=> !pslverr)
    else $error("error on mapped address");
  a_err_zero: assert property (pslverr |-> pready && prdata == 0)
    else $error("error without ready or with data");
  a_ack_clear: assert property (
    cmpa_irq_ack && !timer_tick && !$past(timer_tick)
    |-> ##[1:2] !compare_a_irq)
    else $error("compare irq not cleared by ack");
  a_irq_tick: assert property (
    $rose(compare_a_irq) && !$past(psel) && !$past(psel, 2)
    |-> $past(timer_tick) || $past(timer_tick, 2)
    || $past(timer_tick, 3))
    else $error("compare irq without timer tick");
endmodule
bind timer16_capture_compare timer16_cc_monitor mon (.*);

// *** testbench/timer16_capture_compare_test.sv ***
// self-checking bench of the timer capture/compare block
`timescale 1ns/100ps
`include "timer16_cc_defines.vh"
module timer16_capture_compare_test;
  reg clock, reset, timer_tick, tick_on, go, sel;
  reg capt_irq_ack, cmpa_irq_ack, psel, penable, pwrite;
  reg [7:0] paddr;
  reg [31:0] pwdata, rnd;
  reg [3:0] width;
  reg [1:0] tc;
  reg [32:0] notes[$];
  wire clock_enable = 1'b1;
  wire cmpb_irq_ack = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, capture_irq, compare_a_irq, compare_b_irq;
  wire capture_input_pin, comparator_output;
  wire [1:0] compare_output_state;
  integer errors, checked, d0, d1, i;
  timer16_capture_compare dut (.*);
  event_source src (.*);
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [32:0] g, input [32:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("ERROR %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      n = 0;
      @(posedge clock);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge clock);
        n = n + 1;
      end
      if (n == 20) errors = errors + 1;
      psel <= 0;
      penable <= 0;
      @(posedge clock);
    end
  endtask
  task rd(input [7:0] a, input err, input [31:0] e);
    begin
      notes.push_back({err, e});
      apb(0, a, 0);
    end
  endtask
  task wait_irq(output integer d);
    begin
      d = 0;
      while (capture_irq !== 1'b1 && d < 40) begin
        @(posedge clock);
        d = d + 1;
      end
    end
  endtask
  task meas(input s, input [3:0] w, output integer d);
    begin
      sel <= s;
      width <= w;
      go <= 1;
      @(posedge clock);
      go <= 0;
      wait_irq(d);
      repeat (20) @(posedge clock);
    end
  endtask
  task stop_test;
    begin
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    tc <= tc + 2'h1;
    timer_tick <= tick_on && tc == 2'h3;
  end
  always @(posedge clock)
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, notes.pop_front());
  initial begin
    #100000;
    errors = errors + 1;
    stop_test;
  end
  initial begin
    {reset, timer_tick, tick_on, go, sel, tc} = 7'h40;
    {capt_irq_ack, cmpa_irq_ack, psel, penable, pwrite} = 5'h0;
    {paddr, pwdata, width} = 44'h0;
    errors = 0;
    checked = 0;
    rnd = lfsr(32'h3872);
    repeat (16) @(posedge clock);
    reset <= 0;
    @(posedge clock);
    rd(`TCC_CTRL_B, 0, 0);
    rd(8'h40, 1, 0);
    rd(8'h06, 1, 0);
    $display("map done");
    apb(1, `TCC_CMP_A_HIGH, {24'h0, rnd[7:0]});
    apb(1, `TCC_CMP_A_LOW, {24'h0, rnd[15:8]});
    apb(1, `TCC_CMP_B_LOW, {24'h0, rnd[23:16]});
    rd(`TCC_CMP_A_HIGH, 0, {24'h0, rnd[7:0]});
    rd(`TCC_CMP_A_LOW, 0, {24'h0, rnd[15:8]});
    rd(`TCC_CMP_B_HIGH, 0, {24'h0, rnd[7:0]});
    rd(`TCC_CMP_B_LOW, 0, {24'h0, rnd[23:16]});
    apb(1, `TCC_IRQ_MASK, 2);
    apb(1, `TCC_CTRL_B, 1);
    apb(1, `TCC_CMP_A_HIGH, 32'h12);
    apb(1, `TCC_CMP_A_LOW, 32'h34);
    apb(1, `TCC_COUNT, 32'h1234);
    tick_on <= 1;
    repeat (40) @(posedge clock);
    chk({32'h0, compare_a_irq}, 0);
    apb(1, `TCC_COUNT, 32'h1231);
    repeat (40) @(posedge clock);
    chk({32'h0, compare_a_irq}, 1);
    rd(`TCC_FLAGS, 0, 2);
    cmpa_irq_ack <= 1;
    @(posedge clock);
    cmpa_irq_ack <= 0;
    repeat (3) @(posedge clock);
    chk({32'h0, compare_a_irq}, 0);
    tick_on <= 0;
    apb(1, `TCC_FLAGS, 7);
    $display("compare done");
    for (i = 1; i < 4; i = i + 1) begin
      apb(1, `TCC_CTRL_A, i << 6);
      apb(1, `TCC_FORCE, 1);
      chk({32'h0, compare_output_state[0]}, i != 2);
    end
    apb(1, `TCC_CTRL_A, 32'hC1);
    chk({32'h0, compare_output_state[0]}, 1);
    rd(`TCC_FLAGS, 0, 0);
    apb(1, `TCC_CTRL_A, 0);
    $display("force done");
    apb(1, `TCC_IRQ_MASK, 1);
    apb(1, `TCC_CTRL_B, 32'h41);
    apb(1, `TCC_COUNT, {16'h0, rnd[15:0]});
    meas(0, 8, d0);
    apb(1, `TCC_COUNT, {16'h0, rnd[31:16]});
    meas(0, 8, d1);
    rd(`TCC_CAPTURE, 0, {16'h0, rnd[31:16]});
    rd(`TCC_FLAGS, 0, 1);
    capt_irq_ack <= 1;
    @(posedge clock);
    capt_irq_ack <= 0;
    repeat (3) @(posedge clock);
    chk({32'h0, capture_irq}, 0);
    apb(1, `TCC_ANCMP_CTRL, 1);
    apb(1, `TCC_FLAGS, 1);
    meas(1, 8, d1);
    chk({32'h0, d1 < 40}, 1);
    apb(1, `TCC_FLAGS, 1);
    meas(0, 8, d1);
    chk(d1, 40);
    apb(1, `TCC_ANCMP_CTRL, 0);
    apb(1, `TCC_FLAGS, 1);
    apb(1, `TCC_PORT_OUT, 1);
    wait_irq(d1);
    chk({32'h0, d1 < 40}, 1);
    apb(1, `TCC_PORT_OUT, 0);
    apb(1, `TCC_CTRL_B, 32'hC1);
    apb(1, `TCC_FLAGS, 1);
    meas(0, 8, d1);
    chk(d1 - d0, 4);
    apb(1, `TCC_FLAGS, 1);
    meas(0, 3, d1);
    chk(d1, 40);
    apb(1, `TCC_CTRL_B, 32'h81);
    apb(1, `TCC_FLAGS, 1);
    meas(0, 8, d1);
    chk(d1 - d0, 12);
    apb(1, `TCC_CTRL_B, 32'h71);
    apb(1, `TCC_FLAGS, 1);
    meas(0, 8, d1);
    chk(d1, 40);
    $display("capture done");
    stop_test;
  end
endmodule
